/* rtl/pmp_cfg.svh */
// Overview of operation
// RULE1 - Boot select low at reset: start fetching from on-chip ROM at FF80h.
// RULE2 - The ROM word at the reset location branches to the bootloader start.
// RULE3 - On-chip ROM is 16K words of 16 bits.
// RULE4 - Page decode: external 0000-BFFF, boot F800-FBFF, vectors FF80-FFFF, rest reserved.
// RULE5 - Words FF00h-FF7Fh are kept for factory test, not application code.
// RULE6 - Dual-access RAM is four independent banks of 8K words.
// RULE7 - Each bank takes two reads, or one read and one write, per cycle.
// RULE8 - RAM decodes at data 0080h-7FFFh and in program space when overlay is set.
// RULE9 - Reset, interrupt or trap loads the PC with the vector address.
// RULE10 - Each vector slot spans four program words.
// RULE11 - After reset the vector base follows the vector page pointer.
// RULE12 - Reset sets the vector page pointer to all ones, so reset fetches FF80h.
// RULE13 - The device drives 23 program address lines, 8M words.
// RULE14 - Page select register sits at data address 001Eh, reset to zero.
// RULE15 - Far branch, call, return and return-enable load the page register.
// RULE16 - Table read and write take a full 23-bit accumulator address.
// RULE17 - Nothing else changes the page register; accesses stay in the page.
// RULE18 - Extended space is 127 pages of 64K words.
// RULE19 - Overlay set maps lower 32K of every page to on-chip RAM; here only 0080h-7FFFh do, 0000h-007Fh decode as reserved.
// RULE20 - Boot select high at reset sends the reset fetch to external memory.
// RULE21 - External address is page register joined above the 16-bit address.
`ifndef PMP_CFG_SVH
`define PMP_CFG_SVH
`define PMP_IDX_MODE 8'h1D
`define PMP_IDX_PAGE 8'h1E
`define PMP_IDX_STAT 8'h1F
`define PMP_VEC_PTR_LSB 7
`define PMP_OVERLAY_BIT 5
`define PMP_STAT_BOOT_BIT 0
`define PMP_STAT_PAGE_LSB 8
`define PMP_VEC_PTR_RST 9'h1FF
`define PMP_OVERLAY_RST 1'b0
`define PMP_PAGE_RST 7'h00
`define PMP_PAGE_MAX 7'h7E
`define PMP_RST_VEC 16'hFF80
`define PMP_EXT_TOP 16'hBFFF
`define PMP_BOOT_LO 16'hF800
`define PMP_BOOT_HI 16'hFBFF
`define PMP_TEST_LO 16'hFF00
`define PMP_VEC_LO 16'hFF80
`define PMP_RAM_LO 16'h0080
`define PMP_RAM_HI 16'h7FFF
`endif

/* rtl/pmp_pkg.sv */
package pmp_pkg;
  typedef enum logic [2:0] {
    FAR_NONE = 3'h0,
    FAR_BR_IMM = 3'h1,
    FAR_BR_ACC = 3'h2,
    FAR_CALL_IMM = 3'h3,
    FAR_CALL_ACC = 3'h4,
    FAR_RET = 3'h5,
    FAR_RETE = 3'h6
  } pmp_far_e;
  typedef enum logic [3:0] {
    TGT_EXT = 4'h1,
    TGT_ROM = 4'h2,
    TGT_RAM = 4'h4,
    TGT_RSV = 4'h8
  } pmp_tgt_e;
  typedef enum logic [1:0] {
    ST_BOOT = 2'h1,
    ST_RUN = 2'h2
  } pmp_state_e;
endpackage : pmp_pkg

/* rtl/pmp_top.sv */
// Register access over APB is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
`include "pmp_cfg.svh"
module pmp_top #(
  parameter int ROM_WORDS = 16384,
  parameter int RAM_BANKS = 4,
  parameter int BANK_WORDS = 8192
) (
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  input wire logic BOOT_SOURCE_SELECT_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic FETCH_REQ_I,
  input wire logic [15:0] FETCH_ADDR_I,
  input wire logic TBL_REQ_I,
  input wire logic TBL_WR_I,
  input wire logic [22:0] TBL_ACC_I,
  input wire pmp_pkg::pmp_far_e FAR_OP_I,
  input wire logic [22:0] FAR_IMM_I,
  input wire logic [22:0] FAR_ACC_I,
  input wire logic [22:0] FAR_STACK_I,
  input wire logic VEC_REQ_I,
  input wire logic [4:0] VEC_NUM_I,
  input wire logic DATA_REQ_I,
  input wire logic DATA_WR_I,
  input wire logic [15:0] DATA_ADDR_I,
  output logic [22:0] PROG_ADDR_O,
  output logic PROG_EXT_REQ_O,
  output logic PROG_ROM_REQ_O,
  output logic PROG_RAM_REQ_O,
  output logic PROG_RSV_O,
  output logic PROG_WR_O,
  output logic [13:0] ROM_ADDR_O,
  output logic [3:0] RAM_A_BANK_O,
  output logic [12:0] RAM_A_ADDR_O,
  output logic RAM_A_WR_O,
  output logic [3:0] RAM_B_BANK_O,
  output logic [12:0] RAM_B_ADDR_O,
  output logic RAM_B_WR_O,
  output logic DATA_STALL_O,
  output logic PC_LOAD_O,
  output logic [15:0] PC_VALUE_O,
  output logic INT_ENABLE_O,
  output logic FAR_REFUSED_O,
  output logic [6:0] PAGE_O
);
  import pmp_pkg::*;

  initial
  begin
    if (ROM_WORDS != 16384 || RAM_BANKS != 4 || BANK_WORDS != 8192)
    begin
      $error("pmp_top: decode is fixed to 16K ROM and four 8K RAM banks");
    end
  end

  pmp_state_e state_reg;
  logic boot_sel_reg;
  logic [6:0] page_reg;
  logic [6:0] page_next;
  logic [8:0] vec_ptr_reg;
  logic overlay_reg;
  logic boot_src;
  logic [22:0] far_tgt;
  logic far_take;
  logic far_bad;
  logic [22:0] acc_addr;
  logic acc_req;
  pmp_tgt_e acc_tgt;
  logic [15:0] vec_addr;
  logic apb_setup;
  logic apb_wr;
  logic [7:0] apb_idx;
  logic apb_hit;
  logic [31:0] apb_rd;
  logic data_ram;
  logic data_clash;

  // Address decode of one 23-bit program address.
  function automatic pmp_tgt_e decode(input logic [22:0] a, input logic ov, input logic bs);
    logic [15:0] lo;
    lo = a[15:0];
    if (a[22:16] > `PMP_PAGE_MAX) // RULE18
    begin
      decode = TGT_RSV;
    end
    else if (lo <= `PMP_EXT_TOP) // RULE4
    begin
      if (ov && !lo[15]) // RULE19
      begin
        decode = (lo >= `PMP_RAM_LO) ? TGT_RAM : TGT_RSV; // RULE8
      end
      else
      begin
        decode = TGT_EXT;
      end
    end
    else if (bs || a[22:16] != 7'h00) // RULE20
    begin
      decode = TGT_EXT;
    end
    else if ((lo >= `PMP_BOOT_LO && lo <= `PMP_BOOT_HI) || lo >= `PMP_VEC_LO) // RULE4
    begin
      decode = TGT_ROM;
    end
    else
    begin
      // Factory test words fall here, as do the other holes
      decode = TGT_RSV; // RULE5
    end
  endfunction : decode

  // Far target source
  always_comb
  begin
    far_tgt = FAR_IMM_I;
    unique case (FAR_OP_I)
      FAR_BR_ACC, FAR_CALL_ACC: far_tgt = FAR_ACC_I; // RULE15
      FAR_RET, FAR_RETE: far_tgt = FAR_STACK_I;
      default: far_tgt = FAR_IMM_I;
    endcase
  end

  // A far jump into the missing top page is dropped, page kept
  assign far_bad = far_tgt[22:16] > `PMP_PAGE_MAX;
  assign far_take = state_reg == ST_RUN && FAR_OP_I != FAR_NONE && !VEC_REQ_I;

  // Program bus: table access wins over the fetch in the same cycle
  always_comb
  begin
    acc_req = 1'b0;
    acc_addr = {page_reg, FETCH_ADDR_I}; // RULE21
    if (state_reg == ST_BOOT)
    begin
      acc_req = 1'b1;
      acc_addr = {7'h00, `PMP_RST_VEC}; // RULE1
    end
    else if (TBL_REQ_I)
    begin
      acc_req = 1'b1;
      acc_addr = TBL_ACC_I; // RULE16
    end
    else if (FETCH_REQ_I)
    begin
      acc_req = 1'b1;
      acc_addr = {page_reg, FETCH_ADDR_I}; // RULE17
    end
  end

  // Strap is live in the boot cycle, so the reset fetch already obeys it
  assign boot_src = (state_reg == ST_BOOT) ? BOOT_SOURCE_SELECT_I : boot_sel_reg; // RULE1 RULE20
  assign acc_tgt = decode(acc_addr, overlay_reg, boot_src);
  // Four words per slot on the pointer's 128-word page
  assign vec_addr = {vec_ptr_reg, VEC_NUM_I, 2'b00}; // RULE10 RULE11

  // The strap is caught at the first clocked edge after release
  always_ff @(posedge CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      state_reg <= ST_BOOT;
      boot_sel_reg <= 1'b0;
    end
    else
    begin
      unique case (state_reg)
        ST_BOOT:
        begin
          boot_sel_reg <= BOOT_SOURCE_SELECT_I; // RULE1 RULE20
          state_reg <= ST_RUN;
        end
        ST_RUN: state_reg <= ST_RUN;
      endcase
    end
  end

  // Page register: only far instructions and software touch it
  always_comb
  begin
    page_next = page_reg;
    if (far_take && !far_bad)
    begin
      page_next = far_tgt[22:16]; // RULE15
    end
    else if (apb_wr && apb_idx == `PMP_IDX_PAGE && PWDATA_I[6:0] <= `PMP_PAGE_MAX)
    begin
      page_next = PWDATA_I[6:0]; // RULE14 RULE18
    end
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      page_reg <= `PMP_PAGE_RST; // RULE14
    end
    else
    begin
      page_reg <= page_next; // RULE17
    end
  end

  // Mode register: vector pointer and overlay
  always_ff @(posedge CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      vec_ptr_reg <= `PMP_VEC_PTR_RST; // RULE12
      overlay_reg <= `PMP_OVERLAY_RST;
    end
    else if (apb_wr && apb_idx == `PMP_IDX_MODE)
    begin
      vec_ptr_reg <= PWDATA_I[`PMP_VEC_PTR_LSB +: 9]; // RULE11
      overlay_reg <= PWDATA_I[`PMP_OVERLAY_BIT]; // RULE8
    end
  end

  // PC load: reset vector, then vectors, then far targets
  always_ff @(posedge CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      PC_LOAD_O <= 1'b0;
      PC_VALUE_O <= 16'h0000;
      INT_ENABLE_O <= 1'b0;
      FAR_REFUSED_O <= 1'b0;
    end
    else
    begin
      PC_LOAD_O <= 1'b0;
      INT_ENABLE_O <= 1'b0;
      FAR_REFUSED_O <= 1'b0;
      if (state_reg == ST_BOOT)
      begin
        // ROM word here branches on to the bootloader
        PC_LOAD_O <= 1'b1; // RULE2 RULE12
        PC_VALUE_O <= `PMP_RST_VEC;
      end
      else if (VEC_REQ_I)
      begin
        PC_LOAD_O <= 1'b1; // RULE9
        PC_VALUE_O <= vec_addr;
      end
      else if (far_take && far_bad)
      begin
        FAR_REFUSED_O <= 1'b1;
      end
      else if (far_take)
      begin
        PC_LOAD_O <= 1'b1; // RULE15
        PC_VALUE_O <= far_tgt[15:0];
        INT_ENABLE_O <= FAR_OP_I == FAR_RETE;
      end
    end
  end

  // Program-side bus outputs
  always_ff @(posedge CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      PROG_ADDR_O <= 23'h000000;
      PROG_EXT_REQ_O <= 1'b0;
      PROG_ROM_REQ_O <= 1'b0;
      PROG_RAM_REQ_O <= 1'b0;
      PROG_RSV_O <= 1'b0;
      PROG_WR_O <= 1'b0;
      ROM_ADDR_O <= 14'h0000;
      RAM_A_ADDR_O <= 13'h0000;
      RAM_A_WR_O <= 1'b0;
    end
    else
    begin
      PROG_ADDR_O <= acc_addr; // RULE13 RULE21
      PROG_EXT_REQ_O <= acc_req && acc_tgt == TGT_EXT;
      PROG_ROM_REQ_O <= acc_req && acc_tgt == TGT_ROM && !(TBL_REQ_I && TBL_WR_I && state_reg == ST_RUN);
      PROG_RAM_REQ_O <= acc_req && acc_tgt == TGT_RAM;
      // ROM writes are reported as reserved
      PROG_RSV_O <= acc_req && (acc_tgt == TGT_RSV || (acc_tgt == TGT_ROM && TBL_REQ_I && TBL_WR_I
        && state_reg == ST_RUN));
      PROG_WR_O <= state_reg == ST_RUN && TBL_REQ_I && TBL_WR_I && acc_tgt == TGT_EXT;
      ROM_ADDR_O <= acc_addr[13:0]; // RULE3
      RAM_A_ADDR_O <= acc_addr[12:0];
      RAM_A_WR_O <= state_reg == ST_RUN && TBL_REQ_I && TBL_WR_I && acc_tgt == TGT_RAM;
    end
  end

  // Data side: port B of the RAM
  assign data_ram = DATA_REQ_I && DATA_ADDR_I >= `PMP_RAM_LO && DATA_ADDR_I <= `PMP_RAM_HI; // RULE8
  // Two writes to one bank cannot share a cycle; the data write waits
  assign data_clash = data_ram && DATA_WR_I && state_reg == ST_RUN && TBL_REQ_I && TBL_WR_I
    && acc_tgt == TGT_RAM && acc_addr[14:13] == DATA_ADDR_I[14:13]; // RULE7

  always_ff @(posedge CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      RAM_B_ADDR_O <= 13'h0000;
      RAM_B_WR_O <= 1'b0;
      DATA_STALL_O <= 1'b0;
    end
    else
    begin
      RAM_B_ADDR_O <= DATA_ADDR_I[12:0];
      RAM_B_WR_O <= data_ram && DATA_WR_I && !data_clash; // RULE7
      DATA_STALL_O <= data_clash;
    end
  end

  // Per-bank selects for both ports
  genvar b;
  generate
    for (b = 0; b < 4; b++)
    begin : g_bank
      always_ff @(posedge CLK_I or negedge RESET_N_I)
      begin
        if (!RESET_N_I)
        begin
          RAM_A_BANK_O[b] <= 1'b0;
          RAM_B_BANK_O[b] <= 1'b0;
        end
        else
        begin
          RAM_A_BANK_O[b] <= acc_req && acc_tgt == TGT_RAM && acc_addr[14:13] == 2'(b); // RULE6 RULE19
          RAM_B_BANK_O[b] <= data_ram && !data_clash && DATA_ADDR_I[14:13] == 2'(b); // RULE6
        end
      end
    end
  endgenerate

  always_ff @(posedge CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      PAGE_O <= `PMP_PAGE_RST;
    end
    else
    begin
      // Same edge as the register, so a software write shows at once
      PAGE_O <= page_next;
    end
  end

  // APB slave: no wait states, answer prepared in the setup cycle
  assign apb_setup = PSEL_I && !PENABLE_I;
  assign apb_idx = {2'b00, PADDR_I[7:2]};
  assign apb_hit = PADDR_I[1:0] == 2'b00 && (apb_idx == `PMP_IDX_MODE || apb_idx == `PMP_IDX_PAGE
    || apb_idx == `PMP_IDX_STAT);
  assign apb_wr = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && !PSLVERR_O;

  always_comb
  begin
    apb_rd = 32'h00000000;
    if (apb_idx == `PMP_IDX_MODE)
    begin
      apb_rd[`PMP_VEC_PTR_LSB +: 9] = vec_ptr_reg;
      apb_rd[`PMP_OVERLAY_BIT] = overlay_reg;
    end
    else if (apb_idx == `PMP_IDX_PAGE)
    begin
      apb_rd[6:0] = page_reg; // RULE14
    end
    else if (apb_idx == `PMP_IDX_STAT)
    begin
      apb_rd[`PMP_STAT_BOOT_BIT] = boot_sel_reg;
      apb_rd[`PMP_STAT_PAGE_LSB +: 8] = {state_reg == ST_RUN, page_reg};
    end
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O <= 32'h00000000;
    end
    else
    begin
      PREADY_O <= apb_setup;
      PSLVERR_O <= apb_setup && !apb_hit;
      if (apb_setup)
      begin
        PRDATA_O <= (apb_hit && !PWRITE_I) ? apb_rd : 32'h00000000;
      end
    end
  end
endmodule : pmp_top
`default_nettype wire

/* rtl/pmp_pkg_dummy_placeholder_none.sv */
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

/* sim/pmp_top_chk.sv */
`timescale 1ns/1ns
`default_nettype none
module pmp_top_chk (
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  input wire logic BOOT_SOURCE_SELECT_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PREADY_O,
  input wire logic FETCH_REQ_I,
  input wire logic TBL_REQ_I,
  input wire logic VEC_REQ_I,
  input wire logic PC_LOAD_O,
  input wire logic PROG_ROM_REQ_O,
  input wire logic FAR_REFUSED_O,
  input wire logic [15:0] FETCH_ADDR_I,
  input wire logic [15:0] PC_VALUE_O,
  input wire logic [22:0] TBL_ACC_I,
  input wire logic [22:0] FAR_IMM_I,
  input wire logic [22:0] PROG_ADDR_O,
  input wire logic [4:0] VEC_NUM_I,
  input wire logic [6:0] PAGE_O,
  input wire pmp_pkg::pmp_far_e FAR_OP_I
);
  import pmp_pkg::*;
  logic live_reg;
  // Program-side requests on the first edge after reset are ignored by the block
  always_ff @(posedge CLK_I or negedge RESET_N_I)
    if (!RESET_N_I)
      live_reg <= 1'h0;
    else
      live_reg <= 1'h1;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);
  sequence s_setup;
    PSEL_I && !PENABLE_I;
  endsequence
  sequence s_far_imm;
    live_reg && !VEC_REQ_I && (FAR_OP_I == FAR_BR_IMM || FAR_OP_I == FAR_CALL_IMM);
  endsequence
  property p_apb_ready;
    s_setup |=> PREADY_O ##1 !PREADY_O;
  endproperty
  sequence s_boot_edge;
    RESET_N_I && !live_reg;
  endsequence
  property p_reset_vec;
    s_boot_edge |=> PC_LOAD_O && PC_VALUE_O == 16'hFF80 && PROG_ADDR_O == 23'h00FF80
      && PROG_ROM_REQ_O != $past(BOOT_SOURCE_SELECT_I);
  endproperty
  property p_far;
    s_far_imm ##0 FAR_IMM_I[22:16] != 7'h7F |=>
      PC_LOAD_O && PC_VALUE_O == $past(FAR_IMM_I[15:0]) && PAGE_O == $past(FAR_IMM_I[22:16]);
  endproperty
  property p_refuse;
    s_far_imm ##0 FAR_IMM_I[22:16] == 7'h7F |=> FAR_REFUSED_O && $stable(PAGE_O);
  endproperty
  property p_page_hold;
    live_reg && FAR_OP_I == FAR_NONE && !PSEL_I |=> $stable(PAGE_O);
  endproperty
  property p_vec;
    live_reg && VEC_REQ_I |=> PC_LOAD_O && PC_VALUE_O[6:0] == {$past(VEC_NUM_I), 2'h0} && $stable(PAGE_O);
  endproperty
  property p_fetch;
    live_reg && FETCH_REQ_I && !TBL_REQ_I && !PSEL_I |=> PROG_ADDR_O == {$past(PAGE_O), $past(FETCH_ADDR_I)};
  endproperty
  property p_tbl;
    live_reg && TBL_REQ_I |=> PROG_ADDR_O == $past(TBL_ACC_I);
  endproperty
  a_apb_ready: assert property (p_apb_ready) else $error("no single ready after setup");
  a_reset_vec: assert property (p_reset_vec) else $error("bad reset fetch");
  a_far: assert property (p_far) else $error("far target not loaded");
  a_refuse: assert property (p_refuse) else $error("top page not refused");
  a_page_hold: assert property (p_page_hold) else $error("page moved");
  a_vec: assert property (p_vec) else $error("bad vector load");
  a_fetch: assert property (p_fetch) else $error("bad fetch address");
  a_tbl: assert property (p_tbl) else $error("bad table address");
endmodule : pmp_top_chk
bind pmp_top pmp_top_chk chk (.CLK_I, .RESET_N_I, .BOOT_SOURCE_SELECT_I, .PSEL_I, .PENABLE_I, .PREADY_O,
  .FETCH_REQ_I, .TBL_REQ_I,
  .VEC_REQ_I, .PC_LOAD_O, .PROG_ROM_REQ_O, .FAR_REFUSED_O, .FETCH_ADDR_I, .PC_VALUE_O, .TBL_ACC_I, .FAR_IMM_I,
  .PROG_ADDR_O, .VEC_NUM_I, .PAGE_O, .FAR_OP_I);
`default_nettype wire

/* sim/pmp_ext_mem.sv */
`timescale 1ns/1ns
`default_nettype none
module pmp_ext_mem (
  input wire logic clk_i,
  input wire logic req_i,
  input wire logic [22:0] addr_i,
  output logic [22:0] last_addr_o
);
  // Only the address is kept; no data bus reaches this block
  always_ff @(posedge clk_i)
    if (req_i)
      last_addr_o <= addr_i;
endmodule : pmp_ext_mem
`default_nettype wire

/* sim/program_memory_paging_test.sv */
`timescale 1ns/1ns
`default_nettype none
module program_memory_paging_test;
  import pmp_pkg::*;
  logic clk = 1'h0, rst_n = 1'h0, boot = 1'h0, psel = 1'h0, pen = 1'h0, pwr = 1'h0;
  logic fetch = 1'h0, treq = 1'h0, twr = 1'h0, vreq = 1'h0, dreq = 1'h0, dwr = 1'h0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic [15:0] faddr = 16'h0, daddr = 16'h0;
  logic [22:0] tacc = 23'h0, fimm = 23'h0112AB, facc = 23'h0234CD, fstk = 23'h7E0001;
  pmp_far_e far_op = FAR_NONE;
  logic [4:0] vnum = 5'h03;
  logic [31:0] prdata, q;
  logic pready, pslverr, ext, rom, ram, rsv, pc_ld, int_en, refused, stall, e;
  logic [22:0] prog_addr, last_addr;
  logic [15:0] pc;
  logic [6:0] page;
  logic tw_ext, a_wr, b_wr;
  logic [3:0] a_bank, b_bank;
  logic [12:0] a_addr, b_addr;
  logic [13:0] rom_a;
  int n_fail = 0;
  int checks = 0;
  pmp_top uut (.CLK_I(clk), .RESET_N_I(rst_n), .BOOT_SOURCE_SELECT_I(boot), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .FETCH_REQ_I(fetch), .FETCH_ADDR_I(faddr), .TBL_REQ_I(treq), .TBL_WR_I(twr), .TBL_ACC_I(tacc), .FAR_OP_I(far_op),
    .FAR_IMM_I(fimm), .FAR_ACC_I(facc), .FAR_STACK_I(fstk), .VEC_REQ_I(vreq), .VEC_NUM_I(vnum), .DATA_REQ_I(dreq),
    .DATA_WR_I(dwr), .DATA_ADDR_I(daddr), .PROG_ADDR_O(prog_addr), .PROG_EXT_REQ_O(ext), .PROG_ROM_REQ_O(rom),
    .PROG_RAM_REQ_O(ram), .PROG_RSV_O(rsv), .PROG_WR_O(tw_ext), .ROM_ADDR_O(rom_a), .RAM_A_BANK_O(a_bank),
    .RAM_A_ADDR_O(a_addr), .RAM_A_WR_O(a_wr), .RAM_B_BANK_O(b_bank), .RAM_B_ADDR_O(b_addr), .RAM_B_WR_O(b_wr),
    .DATA_STALL_O(stall), .PC_LOAD_O(pc_ld),
    .PC_VALUE_O(pc), .INT_ENABLE_O(int_en), .FAR_REFUSED_O(refused), .PAGE_O(page));
  pmp_ext_mem mem (.clk_i(clk), .req_i(ext), .addr_i(prog_addr), .last_addr_o(last_addr));
  initial
  begin
    forever #5 clk = ~clk;
  end
  task automatic close_out;
    $display("checks %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'h1;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'h1;
    i = 0;
    do
    begin
      @(posedge clk);
      i++;
    end
    while (pready !== 1'h1 && i < 16);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    pen <= 1'h0;
    if (pready !== 1'h1)
    begin
      n_fail++;
      close_out();
    end
  endtask : apb
  // One request cycle, then look after the answering edge has settled
  task automatic take;
    @(posedge clk);
    fetch <= 1'h0;
    treq <= 1'h0;
    twr <= 1'h0;
    far_op <= FAR_NONE;
    vreq <= 1'h0;
    dreq <= 1'h0;
    dwr <= 1'h0;
    @(negedge clk);
  endtask : take
  task automatic fetch_at(input logic [15:0] a, input logic [3:0] t);
    @(posedge clk);
    fetch <= 1'h1;
    faddr <= a;
    take();
    chk("fetch target", {rsv, ram, rom, ext}, t);
  endtask : fetch_at
  task automatic do_reset(input logic strap);
    @(posedge clk);
    rst_n <= 1'h0;
    boot <= strap;
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    @(negedge clk);
    chk("reset pc", {pc_ld, pc}, {1'h1, 16'hFF80});
    chk("reset fetch", {ext, rom, prog_addr}, {strap, !strap, 23'h00FF80});
    chk("reset page", page, 7'h0);
    apb(1'h0, 8'h74, 32'h0);
    chk("mode reset", q, 32'h0000FF80);
    apb(1'h0, 8'h7C, 32'h0);
    chk("status", q, {16'h0000, 1'h1, 7'h00, 7'h00, strap});
    $display("reset done");
  endtask : do_reset
  task automatic t_page;
    apb(1'h1, 8'h78, 32'h5);
    chk("page write err", e, 1'h0);
    apb(1'h1, 8'h78, 32'h7F);
    apb(1'h0, 8'h78, 32'h0);
    chk("page read", q, 32'h5);
    apb(1'h0, 8'h70, 32'h0);
    chk("unmapped err", e, 1'h1);
    fetch_at(16'h1234, 4'h1);
    chk("ext address", prog_addr, 23'h051234);
    @(negedge clk);
    chk("partner address", last_addr, 23'h051234);
    $display("page test done");
  endtask : t_page
  task automatic t_far;
    pmp_far_e ops[6] = '{FAR_BR_IMM, FAR_BR_ACC, FAR_CALL_IMM, FAR_CALL_ACC, FAR_RET, FAR_RETE};
    logic [22:0] tgt;
    for (int i = 0; i < 6; i++)
    begin
      tgt = i > 3 ? fstk : (i[0] ? facc : fimm);
      @(posedge clk);
      far_op <= ops[i];
      take();
      chk("far pc", {pc_ld, pc}, {1'h1, tgt[15:0]});
      chk("far page", page, tgt[22:16]);
      chk("int enable", int_en, ops[i] == FAR_RETE);
    end
    @(posedge clk);
    fimm <= 23'h7F0000;
    far_op <= FAR_BR_IMM;
    take();
    chk("refused", {refused, page}, {1'h1, 7'h7E});
    $display("far test done");
  endtask : t_far
  task automatic t_vec;
    apb(1'h1, 8'h74, 32'h00000200);
    @(posedge clk);
    vreq <= 1'h1;
    far_op <= FAR_BR_ACC;
    take();
    chk("vector", {pc_ld, pc, page}, {1'h1, 16'h020C, 7'h7E});
    $display("vector test done");
  endtask : t_vec
  task automatic t_decode;
    apb(1'h1, 8'h78, 32'h0);
    fetch_at(16'hBFFF, 4'h1);
    fetch_at(16'hC000, 4'h8);
    fetch_at(16'hF800, 4'h2);
    chk("rom address", rom_a, 14'h3800);
    fetch_at(16'hFF00, 4'h8);
    fetch_at(16'hFF80, 4'h2);
    apb(1'h1, 8'h74, 32'h0000FFA0);
    apb(1'h1, 8'h78, 32'h3);
    fetch_at(16'h0100, 4'h4);
    fetch_at(16'h8000, 4'h1);
    @(posedge clk);
    treq <= 1'h1;
    twr <= 1'h1;
    tacc <= 23'h455555;
    dreq <= 1'h1;
    dwr <= 1'h1;
    daddr <= 16'h4000;
    take();
    chk("table", {ram, prog_addr}, {1'h1, 23'h455555});
    chk("stall", stall, 1'h1);
    chk("bank a", {a_wr, a_bank, a_addr}, {1'h1, 4'h4, 13'h1555});
    chk("port b held", {b_wr, b_bank}, 5'h00);
    @(posedge clk);
    treq <= 1'h1;
    twr <= 1'h1;
    tacc <= 23'h018000;
    dreq <= 1'h1;
    dwr <= 1'h1;
    daddr <= 16'h2345;
    take();
    chk("no stall", stall, 1'h0);
    chk("ext write", {tw_ext, ext, a_bank}, {1'h1, 1'h1, 4'h0});
    chk("bank b", {b_wr, b_bank, b_addr}, {1'h1, 4'h2, 13'h0345});
    $display("decode test done");
  endtask : t_decode
  initial
  begin
    do_reset(1'h0);
    t_page();
    t_far();
    t_vec();
    t_decode();
    do_reset(1'h1);
    fetch_at(16'hFF80, 4'h1);
    close_out();
  end
endmodule : program_memory_paging_test
`default_nettype wire
